// File: core/cmpc_map.svh
// Register offsets, field positions, write masks, reset values and mode codes of the comparator control block.
`ifndef CMPC_MAP_SVH
`define CMPC_MAP_SVH
// ----------------------------------------
// Register word indices and byte addresses
// ----------------------------------------
`define CMPC_IDX_CONV_CTRL_B 8'h03
`define CMPC_IDX_CMP_CTRL 8'h08
`define CMPC_IDX_DIG_OFF 8'h14
`define CMPC_ADDR_CONV_CTRL_B 8'h0C
`define CMPC_ADDR_CMP_CTRL 8'h20
`define CMPC_ADDR_DIG_OFF 8'h50
`define CMPC_ADDR_CONV_A 8'h60
`define CMPC_ADDR_CONV_MUX 8'h64
`define CMPC_ADDR_SYS 8'h68
`define CMPC_ADDR_IRQ_STAT 8'h6C
`define CMPC_ADDR_IRQ_MASK 8'h70
`define CMPC_ADDR_PINS 8'h74
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CMPC_B_NEG_MUX_EN 6
`define CMPC_B_DISABLE 7
`define CMPC_B_BANDGAP 6
`define CMPC_B_RESULT 5
`define CMPC_B_FLAG 4
`define CMPC_B_IRQ_EN 3
`define CMPC_B_RESERVED 2
`define CMPC_B_CONV_EN 7
`define CMPC_B_GLOBAL_IE 7
`define CMPC_B_VEC_ACK 0
// ----------------------------------------
// Write masks and reset values
// ----------------------------------------
`define CMPC_WMASK_CONV_CTRL_B 8'hE7
`define CMPC_WMASK_CMP_CTRL 8'hCB
`define CMPC_WMASK_DIG_OFF 8'h3F
`define CMPC_RST_8 8'h00
`define CMPC_IRQ_W 3
`define CMPC_MODE_TOGGLE 2'h0
`define CMPC_MODE_FALL 2'h2
`define CMPC_MODE_RISE 2'h3
`define CMPC_RESP_OKAY 2'h0
`define CMPC_RESP_SLVERR 2'h2
`endif

// File: core/cmpc_pkg.sv
// Types shared by the comparator control block.
package cmpc_pkg;
	// Write address and data captured from the bus.
	typedef struct packed
	{
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} cmpc_wr_t;
	// Bus slave sequencing states.
	typedef enum logic [1:0]
	{
		CMPC_IDLE = 2'b00,
		CMPC_RESP = 2'b01
	} cmpc_bus_t;
endpackage

// File: core/cmpc_top.sv
// Comparator control logic with input routing, result synchroniser, event detection and AXI4-Lite registers.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "cmpc_map.svh"

// Overview of operation
// - Result high while positive input exceeds negative
// - Mux enable, converter off: channel replaces negative
// - Bandgap select routes reference to positive input
// - Disable bit switches comparator off anytime
// - Result synchronised, one to two cycles delay
// - Flag set on event chosen by mode
// - Mode 00 toggle, 10 fall, 11 rise
// - Interrupt needs flag, enable and global enable
// - Flag cleared by vector or writing one
// - Reserved bit two reads zero always
// - Input-off bit forces port bit zero
module cmpc_top
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CMP_GT_POS_NEG, // Analog comparator raw output for the selected pair.
	input wire logic [1:0] PIN_LEVELS, // Digital levels of negative and positive pins.
	output logic NEG_SEL_CHANNEL, // High when a converter channel replaces the negative pin.
	output logic [1:0] NEG_CHANNEL, // Converter channel routed to the negative input.
	output logic POS_SEL_BANDGAP, // High when the reference feeds the positive input.
	output logic CMP_POWER_OFF, // Switches the analog comparator off.
	output logic [1:0] PIN_BUF_OFF, // Digital input buffer disables, negative then positive.
	output logic CMP_IRQ, // Comparator interrupt request.
	output logic SYS_IRQ, // Masked summary interrupt.
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Merges written byte lane zero into a register under its writable mask.
	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s,
		input logic [7:0] m);
		merge8 = s[0] ? ((old & ~m) | (d[7:0] & m)) : old;
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] conv_b_r; // Converter control B, holds the negative mux enable.
	logic [7:0] cmp_ctrl_r; // Disable, bandgap, enable and mode bits; flag lives apart.
	logic [7:0] dig_off_r; // Digital input disables.
	logic [7:0] conv_a_r; // Converter control A mirror, holds converter enable.
	logic [7:0] conv_mux_r; // Converter mux mirror, holds channel select.
	logic [7:0] sys_r; // Global interrupt enable only; the vector acknowledge bit is not stored.
	logic [2:0] irq_stat_r; // Sticky events: compare flag, rise, fall.
	logic [2:0] irq_mask_r; // Mask of the same layout.
	logic flag_r; // Compare event flag.
	logic sync1_r; // First synchroniser stage, read only by the second.
	logic sync2_r; // Visible compare result.
	logic prev_r; // Result one cycle earlier for edge detection.
	logic [1:0] pins_r; // Port input bits after buffer disables.
	logic aw_hold_r, w_hold_r; // Captured halves of a write.
	cmpc_pkg::cmpc_wr_t wr_r; // Captured write payload.
	cmpc_pkg::cmpc_bus_t wst_r; // Write response state.
	logic vec_ack_r; // One-cycle vector execution strobe.

	// ----------------------------------------
	// Comparator path and events
	// ----------------------------------------
	// The disable bit both powers the comparator down and gates every event source below.
	// Gating here rather than at the flag keeps status and flag consistent while off.
	wire cmp_off = cmp_ctrl_r[`CMPC_B_DISABLE];
	wire [1:0] mode = cmp_ctrl_r[1:0];
	// Edges compare the visible result with its value one cycle earlier.
	wire rise = sync2_r & ~prev_r;
	wire fall = ~sync2_r & prev_r;
	// Reserved mode 01 raises no compare event, a safe reading of an undefined code.
	wire cmp_evt = !cmp_off & ((mode == `CMPC_MODE_TOGGLE & (rise | fall)) | (mode == `CMPC_MODE_FALL & fall)
		| (mode == `CMPC_MODE_RISE & rise));
	// The converter owns its multiplexer while enabled, so channel routing waits for it to be off.
	wire neg_ch = conv_b_r[`CMPC_B_NEG_MUX_EN] & !conv_a_r[`CMPC_B_CONV_EN];

	// Synchroniser freezes while off, so a result change that lasts through the off time fires an event once it is back on.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r <= 1'b0;
		end
		else if (!cmp_off)
		begin
			sync1_r <= CMP_GT_POS_NEG;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	// Routing and pin outputs, registered so every output comes from a flop.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			NEG_SEL_CHANNEL <= 1'b0;
			NEG_CHANNEL <= 2'b00;
			POS_SEL_BANDGAP <= 1'b0;
			CMP_POWER_OFF <= 1'b0;
			PIN_BUF_OFF <= 2'b00;
			pins_r <= 2'b00;
			CMP_IRQ <= 1'b0;
			SYS_IRQ <= 1'b0;
		end
		else
		begin
			NEG_SEL_CHANNEL <= neg_ch;
			NEG_CHANNEL <= neg_ch ? conv_mux_r[1:0] : 2'b00;
			POS_SEL_BANDGAP <= cmp_ctrl_r[`CMPC_B_BANDGAP];
			CMP_POWER_OFF <= cmp_off;
			PIN_BUF_OFF <= dig_off_r[1:0];
			pins_r <= PIN_LEVELS & ~dig_off_r[1:0];
			// The request is registered, so it follows the flag by one cycle.
			CMP_IRQ <= flag_r & cmp_ctrl_r[`CMPC_B_IRQ_EN] & sys_r[`CMPC_B_GLOBAL_IE];
			SYS_IRQ <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ----------------------------------------
	// Bus slave: write path
	// ----------------------------------------
	// A channel is taken at the edge where its valid and ready are both high.
	wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
	wire w_take = S_AXI_WVALID & S_AXI_WREADY;
	wire have_aw = aw_hold_r | aw_take;
	wire have_w = w_hold_r | w_take;
	wire wr_go = have_aw & have_w & (wst_r == cmpc_pkg::CMPC_IDLE);
	// Whichever half arrives in this cycle is used directly, the other comes from the holding register.
	// This lets the write land at the same edge as the later handshake, without an extra state.
	wire [7:0] wa = aw_take ? S_AXI_AWADDR : wr_r.addr;
	wire [31:0] wd = w_take ? S_AXI_WDATA : wr_r.data;
	wire [3:0] ws = w_take ? S_AXI_WSTRB : wr_r.strb;
	wire wa_ok = (wa == `CMPC_ADDR_CONV_CTRL_B) | (wa == `CMPC_ADDR_CMP_CTRL) | (wa == `CMPC_ADDR_DIG_OFF)
		| (wa == `CMPC_ADDR_CONV_A) | (wa == `CMPC_ADDR_CONV_MUX) | (wa == `CMPC_ADDR_SYS)
		| (wa == `CMPC_ADDR_IRQ_STAT) | (wa == `CMPC_ADDR_IRQ_MASK);
	wire we_ctrl = wr_go & (wa == `CMPC_ADDR_CMP_CTRL) & ws[0];
	wire flag_w1c = we_ctrl & wd[`CMPC_B_FLAG];
	wire stat_w1c = wr_go & (wa == `CMPC_ADDR_IRQ_STAT) & ws[0];
	// Status events mirror the flag event plus raw edges, independent of the selected mode.
	wire [2:0] evts = {cmp_evt, rise & !cmp_off, fall & !cmp_off};

	// Address and data channels are taken in either order, held until both are in.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			wr_r <= '0;
			wst_r <= cmpc_pkg::CMPC_IDLE;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `CMPC_RESP_OKAY;
		end
		else
		begin
			S_AXI_AWREADY <= !have_aw & (wst_r == cmpc_pkg::CMPC_IDLE) & !S_AXI_AWREADY;
			S_AXI_WREADY <= !have_w & (wst_r == cmpc_pkg::CMPC_IDLE) & !S_AXI_WREADY;
			if (aw_take)
				wr_r.addr <= S_AXI_AWADDR;
			if (w_take)
			begin
				wr_r.data <= S_AXI_WDATA;
				wr_r.strb <= S_AXI_WSTRB;
			end
			case (wst_r)
				cmpc_pkg::CMPC_IDLE:
				begin
					aw_hold_r <= have_aw & !wr_go;
					w_hold_r <= have_w & !wr_go;
					if (wr_go)
					begin
						wst_r <= cmpc_pkg::CMPC_RESP;
						S_AXI_BVALID <= 1'b1;
						S_AXI_BRESP <= wa_ok ? `CMPC_RESP_OKAY : `CMPC_RESP_SLVERR;
					end
				end
				default:
				begin
					if (S_AXI_BREADY)
					begin
						S_AXI_BVALID <= 1'b0;
						wst_r <= cmpc_pkg::CMPC_IDLE;
					end
				end
			endcase
		end
	end

	// Register writes; hardware sets beat software clears in the same cycle.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			conv_b_r <= `CMPC_RST_8;
			cmp_ctrl_r <= `CMPC_RST_8;
			dig_off_r <= `CMPC_RST_8;
			conv_a_r <= `CMPC_RST_8;
			conv_mux_r <= `CMPC_RST_8;
			sys_r <= `CMPC_RST_8;
			irq_mask_r <= 3'b000;
			irq_stat_r <= 3'b000;
			flag_r <= 1'b0;
			vec_ack_r <= 1'b0;
		end
		else
		begin
			// Vector execution is a write-only strobe; it clears the flag one cycle after the write lands.
			vec_ack_r <= wr_go & (wa == `CMPC_ADDR_SYS) & ws[0] & wd[`CMPC_B_VEC_ACK];
			if (wr_go & (wa == `CMPC_ADDR_CONV_CTRL_B))
				conv_b_r <= merge8(conv_b_r, wd, ws, `CMPC_WMASK_CONV_CTRL_B);
			if (we_ctrl)
				cmp_ctrl_r <= merge8(cmp_ctrl_r, wd, ws, `CMPC_WMASK_CMP_CTRL);
			if (wr_go & (wa == `CMPC_ADDR_DIG_OFF))
				dig_off_r <= merge8(dig_off_r, wd, ws, `CMPC_WMASK_DIG_OFF);
			if (wr_go & (wa == `CMPC_ADDR_CONV_A))
				conv_a_r <= merge8(conv_a_r, wd, ws, 8'hFF);
			if (wr_go & (wa == `CMPC_ADDR_CONV_MUX))
				conv_mux_r <= merge8(conv_mux_r, wd, ws, 8'hFF);
			if (wr_go & (wa == `CMPC_ADDR_SYS))
				sys_r <= merge8(sys_r, wd, ws, 8'h80);
			if (wr_go & (wa == `CMPC_ADDR_IRQ_MASK) & ws[0])
				irq_mask_r <= wd[2:0];
			// Set wins over clear for both the status bits and the flag, so only an event at the edge of a vector write is lost.
			irq_stat_r <= (irq_stat_r & ~(stat_w1c ? wd[2:0] : 3'b000)) | evts;
			flag_r <= (flag_r & !(flag_w1c | vec_ack_r)) | cmp_evt;
		end
	end

	// ----------------------------------------
	// Bus slave: read path
	// ----------------------------------------
	// The result bit is read-only and reflects the synchroniser output, not the raw comparator.
	// Reserved bit two is hard-wired low, whatever was written.
	wire [7:0] ctrl_rd = {cmp_ctrl_r[7:6], sync2_r, flag_r, cmp_ctrl_r[3], 1'b0, cmp_ctrl_r[1:0]};
	wire [7:0] ra = S_AXI_ARADDR;
	wire [7:0] rd_val;
	wire rd_ok;
	// Address decode for reads; an unmapped address returns zero with an error response.
	assign rd_val = (ra == `CMPC_ADDR_CONV_CTRL_B) ? conv_b_r
		: (ra == `CMPC_ADDR_CMP_CTRL) ? ctrl_rd
		: (ra == `CMPC_ADDR_DIG_OFF) ? dig_off_r
		: (ra == `CMPC_ADDR_CONV_A) ? conv_a_r
		: (ra == `CMPC_ADDR_CONV_MUX) ? conv_mux_r
		: (ra == `CMPC_ADDR_SYS) ? sys_r
		: (ra == `CMPC_ADDR_IRQ_STAT) ? {5'b00000, irq_stat_r}
		: (ra == `CMPC_ADDR_IRQ_MASK) ? {5'b00000, irq_mask_r}
		: (ra == `CMPC_ADDR_PINS) ? {6'b000000, pins_r}
		: 8'h00;
	assign rd_ok = (ra == `CMPC_ADDR_CONV_CTRL_B) | (ra == `CMPC_ADDR_CMP_CTRL) | (ra == `CMPC_ADDR_DIG_OFF)
		| (ra == `CMPC_ADDR_CONV_A) | (ra == `CMPC_ADDR_CONV_MUX) | (ra == `CMPC_ADDR_SYS)
		| (ra == `CMPC_ADDR_IRQ_STAT) | (ra == `CMPC_ADDR_IRQ_MASK) | (ra == `CMPC_ADDR_PINS);

	// One read at a time: ready pulses, data follows one cycle later and stands until taken.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= `CMPC_RESP_OKAY;
		end
		else
		begin
			S_AXI_ARREADY <= S_AXI_ARVALID & !S_AXI_ARREADY & !S_AXI_RVALID;
			if (S_AXI_ARVALID & S_AXI_ARREADY)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= {24'h00_0000, rd_val};
				S_AXI_RRESP <= rd_ok ? `CMPC_RESP_OKAY : `CMPC_RESP_SLVERR;
			end
			else if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end
endmodule // cmpc_top

// File: sim/cmpc_chk.sv
// Port-level assertions for the comparator control block.
`timescale 1ns/10ps
`include "cmpc_map.svh"
module cmpc_chk
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic NEG_SEL_CHANNEL,
	input wire logic [1:0] NEG_CHANNEL,
	input wire logic POS_SEL_BANDGAP,
	input wire logic CMP_POWER_OFF,
	input wire logic [1:0] PIN_BUF_OFF,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	// Address of the read in flight, so read data can be judged per register.
	logic [7:0] rd_addr_r;
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	// Captured on the address handshake; the answer follows later.
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
			rd_addr_r <= 8'h00;
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
			rd_addr_r <= S_AXI_ARADDR;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence ar_take;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence
	// Settings may only move as the result of a finished write.
	sequence wr_done;
		S_AXI_BVALID || $past(S_AXI_BVALID);
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	cfg_by_write_a: assert property ($changed({NEG_SEL_CHANNEL, NEG_CHANNEL, POS_SEL_BANDGAP, CMP_POWER_OFF,
		PIN_BUF_OFF}) |-> wr_done) else $error("Setting output moved without a write.");
	chan_idle_a: assert property (!NEG_SEL_CHANNEL |-> NEG_CHANNEL == 2'h0)
		else $error("Channel number shown while pin selected.");
	resv_zero_a: assert property (S_AXI_RVALID && rd_addr_r == `CMPC_ADDR_CMP_CTRL
		|-> S_AXI_RDATA[2] == 1'b0 && S_AXI_RDATA[31:8] == 24'h00_0000) else $error("Reserved bit read as one.");
	pin_off_a: assert property (S_AXI_RVALID && rd_addr_r == `CMPC_ADDR_PINS
		|-> (S_AXI_RDATA[1:0] & PIN_BUF_OFF) == 2'h0) else $error("Disabled pin read as one.");
	rd_answer_a: assert property (ar_take |=> S_AXI_RVALID) else $error("Read answer late.");
	rd_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("Read answer dropped early.");
	aw_pulse_a: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY) else $error("Address ready held.");
	b_refuse_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("Write taken while response pending.");
	b_done_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("Response repeated.");
endmodule // cmpc_chk
bind cmpc_top cmpc_chk chk_u (.CLK(CLK), .RST_N(RST_N), .NEG_SEL_CHANNEL(NEG_SEL_CHANNEL), .NEG_CHANNEL(NEG_CHANNEL),
	.POS_SEL_BANDGAP(POS_SEL_BANDGAP), .CMP_POWER_OFF(CMP_POWER_OFF), .PIN_BUF_OFF(PIN_BUF_OFF),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY));

// File: sim/cmpc_top_tb.sv
// Self-checking bench for the comparator control block.
`timescale 1ns/10ps
`include "cmpc_map.svh"
module cmpc_top_tb;
	logic clk = 1'b0, rst_n = 1'b0, gt = 1'b0, neg_sel, bg, pwr_off, cmp_irq, sys_irq;
	logic [1:0] lvl = 2'h0, neg_ch, buf_off, bresp, rresp, rs;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h0000_0000, rdata, rd_v;
	logic [3:0] wstrb = 4'hF;
	integer failures = 0, cmp_count = 0, cyc = 0, seed = 32'h0000_7070, m, i;
	always #50 clk = ~clk;
	cmpc_top dut_u (.CLK(clk), .RST_N(rst_n), .CMP_GT_POS_NEG(gt), .PIN_LEVELS(lvl), .NEG_SEL_CHANNEL(neg_sel),
		.NEG_CHANNEL(neg_ch), .POS_SEL_BANDGAP(bg), .CMP_POWER_OFF(pwr_off), .PIN_BUF_OFF(buf_off),
		.CMP_IRQ(cmp_irq), .SYS_IRQ(sys_irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Model of the event selector: flag position expected after one change of the result to now.
	function automatic logic [31:0] evt_bit(input integer md, input integer now);
		evt_bit = ((md == 0) || (md == 2 && now == 0) || (md == 3 && now == 1)) ? 32'h0000_0010 : 32'h0000_0000;
	endfunction
	// Address and data go out together; each is dropped once taken. Three idle edges follow.
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bvalid)
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		rs = bresp;
		bready <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rvalid)
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end
		rd_v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_v, e);
	endtask
	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// A hang is cut short well beyond the few hundred cycles the sequence needs.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			failures++;
			print_verdict;
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rc(`CMPC_ADDR_CMP_CTRL, 32'h0000_0000);
		// Unmapped addresses answer with an error on both paths.
		rd(8'h04);
		chk(rs, `CMPC_RESP_SLVERR);
		chk(rd_v, 32'h0000_0000);
		wr(8'h04, 32'h0000_00FF);
		chk(rs, `CMPC_RESP_SLVERR);
		// Interrupt enable stays off while the disable bit moves.
		wr(`CMPC_ADDR_CMP_CTRL, 32'h0000_00F7);
		chk(rs, `CMPC_RESP_OKAY);
		// The reference is given time to settle before any result is trusted.
		repeat (4) @(posedge clk);
		rc(`CMPC_ADDR_CMP_CTRL, 32'h0000_00C3);
		chk({pwr_off, bg}, 2'h3);
		wr(`CMPC_ADDR_CMP_CTRL, 32'h0000_0000);
		chk({pwr_off, bg}, 2'h0);
		wr(`CMPC_ADDR_CONV_CTRL_B, 32'h0000_00FF);
		rc(`CMPC_ADDR_CONV_CTRL_B, 32'h0000_00E7);
		for (i = 0; i < 4; i++)
		begin
			wr(`CMPC_ADDR_CONV_MUX, i);
			chk({neg_sel, neg_ch}, {1'b1, i[1:0]});
		end
		wr(`CMPC_ADDR_CONV_A, 32'h0000_0080);
		chk({neg_sel, neg_ch}, 3'h0);
		for (i = 0; i < 4; i++)
		begin
			lvl <= 2'($random(seed));
			wr(`CMPC_ADDR_DIG_OFF, 32'h0000_003C | i);
			rc(`CMPC_ADDR_PINS, lvl & ~i[1:0]);
			chk(buf_off, i[1:0]);
		end
		// Every mode sees one rise and one fall; the flag is cleared before each.
		for (m = 0; m < 4; m++)
		begin
			wr(`CMPC_ADDR_CMP_CTRL, 32'h0000_0010 | m);
			gt <= 1'b1;
			repeat (4) @(posedge clk);
			rc(`CMPC_ADDR_CMP_CTRL, 32'h0000_0020 | m | evt_bit(m, 1));
			wr(`CMPC_ADDR_CMP_CTRL, 32'h0000_0010 | m);
			gt <= 1'b0;
			repeat (4) @(posedge clk);
			rc(`CMPC_ADDR_CMP_CTRL, m | evt_bit(m, 0));
		end
		wr(`CMPC_ADDR_CMP_CTRL, 32'h0000_0090);
		gt <= 1'b1;
		repeat (4) @(posedge clk);
		rc(`CMPC_ADDR_CMP_CTRL, 32'h0000_0080);
		gt <= 1'b0;
		// The comparator comes back on with the enable still clear, and only then is it enabled.
		wr(`CMPC_ADDR_CMP_CTRL, 32'h0000_0010);
		wr(`CMPC_ADDR_CMP_CTRL, 32'h0000_0018);
		wr(`CMPC_ADDR_SYS, 32'h0000_0080);
		gt <= 1'b1;
		repeat (6) @(posedge clk);
		chk({cmp_irq, sys_irq}, 2'h2);
		wr(`CMPC_ADDR_IRQ_MASK, 32'h0000_0007);
		chk(sys_irq, 1'b1);
		wr(`CMPC_ADDR_IRQ_STAT, 32'h0000_0007);
		chk(sys_irq, 1'b0);
		wr(`CMPC_ADDR_SYS, 32'h0000_0000);
		chk(cmp_irq, 1'b0);
		wr(`CMPC_ADDR_SYS, 32'h0000_0080);
		chk(cmp_irq, 1'b1);
		wr(`CMPC_ADDR_SYS, 32'h0000_0081);
		rc(`CMPC_ADDR_CMP_CTRL, 32'h0000_0028);
		gt <= 1'b0;
		repeat (6) @(posedge clk);
		chk(cmp_irq, 1'b1);
		wr(`CMPC_ADDR_CMP_CTRL, 32'h0000_0018);
		chk(cmp_irq, 1'b0);
		// A second reset in mid-run must bring the routing, power, buffer and interrupt outputs and the status and converter B registers back to zero.
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk({neg_sel, neg_ch, bg, pwr_off, buf_off, cmp_irq, sys_irq}, 9'h000);
		rst_n <= 1'b1;
		rc(`CMPC_ADDR_IRQ_STAT, 32'h0000_0000);
		rc(`CMPC_ADDR_CONV_CTRL_B, 32'h0000_0000);
		print_verdict;
	end
endmodule // cmpc_top_tb
